// ==== twi_pkg.sv ====
// Purpose: shared constants for the two-wire register port and its master
// Assumes: 7-bit addressing, 8-bit register index and data
// Notes: no timescale in a package
package twi_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h60;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int SYS_CLK_HZ = 50000000;
  localparam int SCL_HZ = 100000;
  // half period of the generated bus clock, rounded down
  localparam int HALF_CYCLES = SYS_CLK_HZ / (2 * SCL_HZ);
  localparam logic [7:0] OTP_DEFAULT = 8'h00;
endpackage

// ==== twi_if.sv ====
// Purpose: two-wire bus joining master and target
// Assumes: open-drain lines with pull-ups resolved here
// Notes: a line is low when any party enables its driver
`timescale 1ns/1ps
interface twi_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_t;
  logic sda_oe_t;
  logic scl;
  logic sda;
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_t && !sda_o_t));
  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
    input scl, input sda);
  modport target (output sda_o_t, output sda_oe_t, input scl, input sda);
endinterface

// ==== twi_target.sv ====
// Purpose: two-wire target port giving a host access to the register file
// Assumes: link logic clocked by oversampling clock link_clk; bus pins synchronised
// Notes: register array is local; user side sees write strobes and the current index
//
// Contract
// - works up to 100k, 400k, 1M, 3.4M
// - data changes only while clock low
// - master makes start and stop; detected
// - bus busy from start until stop
// - repeated start restarts address reception
// - eight bits, msb first, then ack slot
// - target acks each received byte, ninth pulse
// - master clocks ack pulse, releases data
// - master nacks last read byte
// - undervoltage: never drive the data line
// - first byte: address then direction bit
// - answer only address 0x60
// - write: index byte then data byte
// - read preceded by index-setting write
// - each further write byte advances index
// - reads never advance the index
// - otp defaults load during memory-load state
// - idle bus lines released high
`timescale 1ns/1ps
module twi_target #(
  parameter int REGS = 256
)(
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic supply_undervoltage_threshold,
  input wire logic otp_load,
  twi_if.target bus,
  output logic bus_busy,
  output logic wr_strobe,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data,
  output logic [7:0] cur_index
);
  // ************************************************************
  // pin synchronisers and condition detection
  // ************************************************************
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic uv_s1_q;
  logic uv_q;
  logic otp_s1_q;
  logic otp_q;
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      uv_s1_q <= 1'b1;
      uv_q <= 1'b1;
      otp_s1_q <= 1'b0;
      otp_q <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
      uv_s1_q <= supply_undervoltage_threshold;
      uv_q <= uv_s1_q;
      otp_s1_q <= otp_load;
      otp_q <= otp_s1_q;
    end
  end
  logic scl_now;
  logic sda_now;
  assign scl_now = scl_s_q[1];
  assign sda_now = sda_s_q[1];
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  assign start_det = scl_now && scl_p_q && sda_p_q && !sda_now;
  assign stop_det = scl_now && scl_p_q && !sda_p_q && sda_now;
  assign scl_rise = scl_now && !scl_p_q;
  assign scl_fall = !scl_now && scl_p_q;
  // ************************************************************
  // byte engine
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INDEX = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } state_type;
  state_type state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] index_q;
  logic rw_q;
  logic drive_q;
  logic sda_val_q;
  logic busy_q;
  logic [7:0] regs_q [REGS];
  logic [7:0] rx_byte;
  assign rx_byte = {shift_q[6:0], sda_now};
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else if (clk_en)
    begin
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;
    end
  end
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      index_q <= twi_pkg::INDEX_RESET;
      rw_q <= 1'b0;
      wr_strobe <= 1'b0;
      wr_index <= 8'h00;
      wr_data <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_strobe <= 1'b0;
      if (start_det)
      begin
        state_q <= ST_ADDR;
        // scl falls once more before the first address bit; wraps to zero there
        bit_q <= 4'hF;
      end
      else if (stop_det)
      begin
        state_q <= ST_IDLE;
      end
      else if (scl_rise && state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
        if (bit_q < twi_pkg::ACK_SLOT)
          shift_q <= rx_byte;
        else if (state_q == ST_RDATA && sda_now)
          state_q <= ST_IGNORE;
      end
      else if (scl_fall && state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
        if (bit_q == twi_pkg::ACK_SLOT - 4'h1)
        begin
          bit_q <= twi_pkg::ACK_SLOT;
          case (state_q)
            ST_ADDR:
            begin
              if (shift_q[7:1] == twi_pkg::TARGET_ADDR)
              begin
                rw_q <= shift_q[0];
              end
              else
                state_q <= ST_IGNORE;
            end
            ST_INDEX:
            begin
              index_q <= shift_q;
            end
            ST_WDATA:
            begin
              wr_strobe <= 1'b1;
              wr_index <= index_q;
              wr_data <= shift_q;
            end
            ST_RDATA: state_q <= ST_RDATA;
            default: state_q <= ST_IGNORE;
          endcase
        end
        else if (bit_q == twi_pkg::ACK_SLOT)
        begin
          bit_q <= 4'h0;
          case (state_q)
            ST_ADDR: state_q <= rw_q ? ST_RDATA : ST_INDEX;
            ST_INDEX: state_q <= ST_WDATA;
            ST_WDATA: index_q <= index_q + 8'h01;
            ST_RDATA: state_q <= ST_RDATA;
            default: state_q <= ST_IGNORE;
          endcase
        end
        else
          bit_q <= bit_q + 4'h1;
      end
    end
  end
  // ************************************************************
  // register file, otp load and read data
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < REGS; gi++)
    begin : g_reg
      always_ff @(posedge link_clk or posedge sys_rst)
      begin
        if (sys_rst)
          regs_q[gi] <= twi_pkg::OTP_DEFAULT;
        else if (clk_en)
        begin
          if (otp_q)
            regs_q[gi] <= twi_pkg::OTP_DEFAULT;
          else if (wr_strobe && wr_index == 8'(gi))
            regs_q[gi] <= wr_data;
        end
      end
    end
  endgenerate
  // drive only on falling clock edges so data is stable through high phase
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_q <= 1'b0;
      sda_val_q <= 1'b1;
    end
    else if (clk_en)
    begin
      if (start_det || stop_det || state_q == ST_IGNORE || state_q == ST_IDLE)
        drive_q <= 1'b0;
      else if (scl_fall)
      begin
        // no ack pulse, not even for one cycle, on a foreign address
        if (bit_q == twi_pkg::ACK_SLOT - 4'h1 && state_q != ST_RDATA &&
          (state_q != ST_ADDR || shift_q[7:1] == twi_pkg::TARGET_ADDR))
        begin
          drive_q <= 1'b1;
          sda_val_q <= 1'b0;
        end
        else if (state_q == ST_RDATA && (bit_q == twi_pkg::ACK_SLOT || bit_q < 4'h7))
        begin
          // first bit after a read byte's ack slot, later bits after each fall
          drive_q <= 1'b1;
          sda_val_q <= regs_q[index_q][bit_q == twi_pkg::ACK_SLOT ? 7 : 6 - bit_q];
        end
        else if (state_q == ST_ADDR && bit_q == twi_pkg::ACK_SLOT && rw_q)
        begin
          drive_q <= 1'b1;
          sda_val_q <= regs_q[index_q][7];
        end
        else
          drive_q <= 1'b0;
      end
    end
  end
  // undervoltage cuts the driver off whatever the engine wants
  assign bus.sda_oe_t = drive_q && !sda_val_q && !uv_q;
  assign bus.sda_o_t = 1'b0;
  assign bus_busy = busy_q;
  assign cur_index = index_q;
endmodule

// ==== twi_master.sv ====
// Purpose: two-wire master issuing register writes and index-then-read
// Assumes: clk at 50 MHz; bus clock made by dividing clk
// Notes: one byte written or read per request; no clock stretching
`timescale 1ns/1ps
module twi_master #(
  parameter int HALF = twi_pkg::HALF_CYCLES
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic req,
  input wire logic req_read,
  input wire logic [7:0] req_index,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [7:0] rd_data,
  twi_if.master bus
);
  // ************************************************************
  // sequencer: phases of quarter bit, bus lines open-drain
  // ************************************************************
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BYTE = 3'b010,
    M_STOP = 3'b011,
    M_RSTART = 3'b100
  } mstate_type;
  mstate_type st_q;
  logic [15:0] cnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic rd_q;
  logic scl_q;
  logic sda_q;
  logic [1:0] sda_s_q;
  logic tick;
  assign tick = cnt_q == 16'((HALF / 2) - 1);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sda_s_q <= 2'h3;
    else if (clk_en)
      sda_s_q <= {sda_s_q[0], bus.sda};
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= M_IDLE;
      cnt_q <= 16'h0000;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      done <= 1'b0;
      nacked <= 1'b0;
      rd_data <= 8'h00;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
      if (st_q == M_IDLE)
      begin
        cnt_q <= 16'h0000;
        ph_q <= 2'h0;
        if (req)
        begin
          st_q <= M_START;
          rd_q <= req_read;
          byte_q <= 3'h0;
          nacked <= 1'b0;
          tx_q <= {twi_pkg::TARGET_ADDR, 1'b0};
        end
      end
      else if (tick)
      begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          M_START, M_RSTART:
          begin
            // ph0 release lines, ph1 sda low with scl high, ph2 scl low
            if (ph_q == 2'h0)
            begin
              sda_q <= 1'b1;
              scl_q <= 1'b1;
            end
            else if (ph_q == 2'h1)
              sda_q <= 1'b0;
            else if (ph_q == 2'h2)
              scl_q <= 1'b0;
            else
            begin
              st_q <= M_BYTE;
              bit_q <= 4'h0;
              ph_q <= 2'h0;
            end
          end
          M_BYTE:
          begin
            if (ph_q == 2'h0)
            begin
              // change data while clock low
              if (bit_q < twi_pkg::ACK_SLOT)
                sda_q <= (byte_q == 3'h3) ? 1'b1 : tx_q[7 - bit_q[2:0]];
              else
                sda_q <= 1'b1; // released: target acks, read byte nacked
            end
            else if (ph_q == 2'h1)
              scl_q <= 1'b1;
            else if (ph_q == 2'h2)
            begin
              if (bit_q < twi_pkg::ACK_SLOT)
                rx_q <= {rx_q[6:0], sda_s_q[1]};
              else if (byte_q != 3'h3 && sda_s_q[1])
                nacked <= 1'b1;
            end
            else
            begin
              scl_q <= 1'b0;
              if (bit_q == twi_pkg::ACK_SLOT)
              begin
                bit_q <= 4'h0;
                byte_q <= byte_q + 3'h1;
                if (nacked || byte_q == 3'h3 || (byte_q == 3'h2 && !rd_q))
                  st_q <= M_STOP;
                else if (byte_q == 3'h1 && rd_q)
                  st_q <= M_RSTART;
                tx_q <= (byte_q == 3'h0) ? req_index :
                  (byte_q == 3'h1 && rd_q) ? {twi_pkg::TARGET_ADDR, 1'b1} : req_data;
                if (byte_q == 3'h3)
                  rd_data <= rx_q;
              end
              else
                bit_q <= bit_q + 4'h1;
            end
          end
          M_STOP:
          begin
            if (ph_q == 2'h0)
              sda_q <= 1'b0;
            else if (ph_q == 2'h1)
              scl_q <= 1'b1;
            else if (ph_q == 2'h2)
              sda_q <= 1'b1;
            else
            begin
              st_q <= M_IDLE;
              done <= 1'b1;
            end
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end
  assign busy = st_q != M_IDLE;
  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_m = !scl_q;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = !sda_q;
endmodule

// ==== twi_assertions.sv ====
// Purpose: protocol checks on the two-wire link between master and target
// Assumes: bench runs the master with HALF of 8, so scl stays high for 8 clk cycles
// Notes: sampled on the master clock, which is far faster than scl
`timescale 1ns/1ps
module twi_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_o_t,
  input wire logic sda_oe_t,
  input wire logic bus_busy,
  input wire logic supply_undervoltage_threshold
);
  logic t_low;
  assign t_low = sda_oe_t && !sda_o_t;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ********************
  // line discipline
  // ********************
  AST_TGT_MOVES_LOW: assert property ($changed(t_low) |-> !scl)
    else $error("target moved sda while scl high");
  AST_NO_TGT_START: assert property (scl && $past(scl) && $fell(sda) |-> !t_low)
    else $error("target made a start edge");
  AST_TGT_BIT_HELD: assert property ($rose(scl) && t_low |-> t_low [*7])
    else $error("target low not held over scl high");
  AST_UV_SILENT: assert property (supply_undervoltage_threshold [*4] |-> !t_low)
    else $error("target drove sda in undervoltage");
  AST_IDLE_HIGH: assert property (!bus_busy [*8] |-> scl && !t_low)
    else $error("line held low on idle bus");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*4])
    else $error("scl high phase too short");
  // ********************
  // session framing
  // ********************
  AST_START_BUSY: assert property (scl && $past(scl) && $fell(sda) |-> ##[1:6] bus_busy)
    else $error("start not seen as busy");
  AST_STOP_FREE: assert property (scl && $past(scl) && $rose(sda) |-> ##[1:6] !bus_busy)
    else $error("stop not seen as free");
  cover property ($rose(bus_busy));
  cover property ($rose(scl) && t_low);
  cover property ($fell(bus_busy));
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench joining the master and target ends
// Assumes: master runs with HALF of 8; link clock free-running at 15 ns
// Notes: expectations queued by the driver, compared by monitors
`timescale 1ns/1ps
module tb;
  logic clk, link_clk, sys_rst, req, req_read, supply_low, otp_load;
  logic busy, done, nacked, bus_busy, wr_strobe;
  logic [7:0] req_index, req_data, rd_data, wr_index, wr_data, cur_index, a, d;
  logic [7:0] mem [256];
  logic [9:0] nq [$];
  logic [9:0] e;
  logic [15:0] wq [$];
  int errors, comparisons, cycles;
  twi_if bus_if ();
  twi_master #(.HALF(8)) i_twi_master (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .req(req), .req_read(req_read), .req_index(req_index), .req_data(req_data),
    .busy(busy), .done(done), .nacked(nacked), .rd_data(rd_data), .bus(bus_if.master));
  twi_target i_twi_target (.link_clk(link_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .supply_undervoltage_threshold(supply_low), .otp_load(otp_load), .bus(bus_if.target),
    .bus_busy(bus_busy), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
    .cur_index(cur_index));
  twi_assertions i_twi_assertions (.clk(clk), .sys_rst(sys_rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .sda_o_t(bus_if.sda_o_t), .sda_oe_t(bus_if.sda_oe_t),
    .bus_busy(bus_busy), .supply_undervoltage_threshold(supply_low));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // ********************
  // helpers
  // ********************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one request; expectations noted before it starts
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] dat);
    logic [7:0] nxt;
    nxt = idx + 8'h01;
    nq.push_back({rd && !supply_low, supply_low, rd ? mem[idx] : 8'h00});
    if (!rd && !supply_low)
    begin
      wq.push_back({idx, dat});
      mem[idx] = dat;
    end
    @(posedge clk);
    req <= 1'b1;
    req_read <= rd;
    req_index <= idx;
    req_data <= dat;
    do @(negedge clk); while (busy !== 1'b1);
    @(posedge clk);
    req <= 1'b0;
    do @(negedge clk); while (busy === 1'b1);
    if (!supply_low)
      check("cur_index", {8'h00, cur_index}, {8'h00, rd ? idx : nxt});
  endtask
  // ********************
  // monitors
  // ********************
  always @(posedge link_clk)
    if (wr_strobe === 1'b1)
      check("write", {wr_index, wr_data}, wq.size() ? wq.pop_front() : {16{1'bX}});
  always @(posedge clk)
    if (done === 1'b1)
    begin
      e = nq.size() ? nq.pop_front() : {10{1'bX}};
      check("nacked", {15'h0000, nacked}, {15'h0000, e[8]});
      if (e[9])
        check("rd_data", {8'h00, rd_data}, {8'h00, e[7:0]});
    end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ********************
  // tests
  // ********************
  initial
  begin
    sys_rst = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    req_index = 8'h00;
    req_data = 8'h00;
    supply_low = 1'b0;
    otp_load = 1'b0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    foreach (mem[i]) mem[i] = twi_pkg::OTP_DEFAULT;
    void'($urandom(32'h7E9C582C));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, 8'h10, 8'hA5);
    xfer(1'b0, 8'hFF, 8'h3C);
    xfer(1'b1, 8'h10, 8'h00);
    xfer(1'b1, 8'hFF, 8'h00);
    $display("test write_read_wrap done");
    for (int i = 0; i < 6; i++)
    begin
      a = 8'($urandom);
      d = 8'($urandom);
      xfer(1'b0, a, d);
      xfer(1'b1, a, 8'h00);
      xfer(1'b1, 8'($urandom), 8'h00);
    end
    $display("test random_back_to_back done");
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h10, 8'h77);
    xfer(1'b1, 8'h10, 8'h00);
    @(posedge clk);
    supply_low <= 1'b0;
    repeat (10) @(posedge clk);
    xfer(1'b1, 8'h10, 8'h00);
    $display("test undervoltage done");
    @(posedge clk);
    otp_load <= 1'b1;
    repeat (10) @(posedge clk);
    otp_load <= 1'b0;
    repeat (10) @(posedge clk);
    foreach (mem[i]) mem[i] = twi_pkg::OTP_DEFAULT;
    xfer(1'b1, 8'h10, 8'h00);
    xfer(1'b1, 8'hFF, 8'h00);
    $display("test otp_reload done");
    repeat (20) @(posedge clk);
    check("pending", 16'(nq.size() + wq.size()), 16'h0000);
    report_and_stop();
  end
endmodule
